//--- hw/lpcs_delay_timer.sv
// one-shot down counter timing sleep and wake intervals
`timescale 1ns/1ps
module lpcs_delay_timer #(
   parameter int CNT_W = 41
) (
   input  wire logic             sys_clk,   // sample clock
   input  wire logic             arst_n,    // async reset, active low
   input  wire logic             clear,     // abort a running interval
   input  wire logic             load,      // start interval
   input  wire logic [CNT_W-1:0] loadValue, // interval length, at least 1
   output logic                  busy,      // interval running
   output logic                  done       // one-cycle expiry pulse
);
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic             busy_r, busy_nxt;

   if (CNT_W < 12) begin : g_bad_width
      $error("lpcs_delay_timer: CNT_W too small");
   end

   assign busy = busy_r;
   assign done = busy_r && (cnt_r == '0);

   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      if (clear) begin
         busy_nxt = 1'b0;
      end else if (load) begin
         cnt_nxt  = loadValue - CNT_W'(1);
         busy_nxt = 1'b1;
      end else if (done) begin
         busy_nxt = 1'b0;
      end else if (busy_r) begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   // elapsed time since load, checked against the programmed length
   logic [CNT_W-1:0] elapsed_r, len_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         elapsed_r <= '0;
         len_r     <= '0;
      end else if (load && !clear) begin
         elapsed_r <= CNT_W'(1);
         len_r     <= loadValue;
      end else begin
         elapsed_r <= elapsed_r + CNT_W'(1);
      end
   end

   a_timer_exact: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      done |-> elapsed_r == len_r)
      else $error("interval expired at the wrong cycle");
endmodule // lpcs_delay_timer

//--- hw/lpcs_pkg.sv
// constants shared by the low-power calibration scheduler
package lpcs_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_SOFT_TRIG  = 8'h6c;
   localparam logic [7:0]  IDX_LP_CTRL    = 8'h6e;
   localparam logic [7:0]  IDX_GAIN_TRIM  = 8'h7a;
   localparam logic [7:0]  IDX_CAL_CFG    = 8'h70;
   localparam logic [7:0]  IDX_STATUS     = 8'h72;
   localparam logic [31:0] ADDR_SOFT_TRIG = {22'h0, IDX_SOFT_TRIG, 2'h0};
   localparam logic [31:0] ADDR_LP_CTRL   = {22'h0, IDX_LP_CTRL, 2'h0};
   localparam logic [31:0] ADDR_GAIN_TRIM = {22'h0, IDX_GAIN_TRIM, 2'h0};
   localparam logic [31:0] ADDR_CAL_CFG   = {22'h0, IDX_CAL_CFG, 2'h0};
   localparam logic [31:0] ADDR_STATUS    = {22'h0, IDX_STATUS, 2'h0};

   // reset values
   localparam logic [7:0] SOFT_TRIG_RST = 8'h01;
   localparam logic [7:0] LP_CTRL_RST   = 8'h88;
   localparam logic [7:0] GAIN_TRIM_RST = 8'h00;
   localparam logic [7:0] CAL_CFG_RST   = 8'h00;

   // field positions
   localparam int SOFT_TRIG_BIT  = 0;
   localparam int LOWPOWER_CAL_ENABLE_BIT      = 0;
   localparam int LOWPOWER_TRIGGER_MODE_BIT    = 1;
   localparam int WAKE_LSB       = 3;
   localparam int SLEEP_LSB      = 5;
   localparam int TRIG_SEL_BIT   = 0;
   localparam int BG_CAL_BIT     = 1;
   localparam int STAT_TRIG_BIT  = 0;
   localparam int STAT_SLEEP_BIT = 1;
   localparam int STAT_WAKE_BIT  = 2;
   localparam int STAT_CAL_BIT   = 3;
   localparam int STAT_FUSE_BIT  = 4;

   // delays in sample clock periods, their exponents and the counter width
   localparam int SHORT_DLY_CYC  = 1152;
   localparam int DLY_BIAS_CYC   = 128;
   localparam int EXP_STEP       = 3;
   localparam int SLEEP_EXP_DEF  = 19;
   localparam int WAKE_EXP_DEF   = 22;
   localparam int CNT_W_DEF      = 41;

   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE, ST_SLEEP, ST_WAKE, ST_CAL
   } lpcs_state_t;
endpackage

//--- hw/lpcs_scheduler.sv
// calibration trigger select, low-power sleep/wake scheduler, gain trim
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module lpcs_scheduler
   import lpcs_pkg::*;
#(
   parameter int CNT_W     = lpcs_pkg::CNT_W_DEF,
   parameter int SLEEP_EXP = lpcs_pkg::SLEEP_EXP_DEF,
   parameter int WAKE_EXP  = lpcs_pkg::WAKE_EXP_DEF
) (
   input  wire logic        sys_clk,       // 250 MHz sample clock
   input  wire logic        arst_n,        // async reset, active low
   input  wire logic        hsel,          // ahb select
   input  wire logic [31:0] haddr,         // ahb address
   input  wire logic [1:0]  htrans,        // ahb transfer type
   input  wire logic        hwrite,        // ahb write
   input  wire logic [2:0]  hsize,         // ahb size, word only
   input  wire logic [31:0] hwdata,        // ahb write data
   input  wire logic        hready,        // ahb bus ready
   output logic             hreadyout,     // always ready
   output logic             hresp,         // always okay
   output logic [31:0]      hrdata,        // registered read data
   input  wire logic        calTriggerPin, // external trigger pin
   input  wire logic        fuseTrimValid, // fuse gain value valid
   input  wire logic [7:0]  fuseTrimValue, // fuse gain value
   input  wire logic        calDone,       // core calibration finished
   output logic             calTrigger,    // selected trigger level
   output logic             coreSleep,     // offline core asleep
   output logic             coreSettling,  // offline core settling
   output logic             calStart,      // start calibration pulse
   output logic [7:0]       gainTrim       // gain trim to all cores
);
   import lpcs_pkg::*;

   if (CNT_W < SLEEP_EXP + 7 * EXP_STEP + 1 ||
       CNT_W < WAKE_EXP + 3 * EXP_STEP + 1 || SLEEP_EXP < 1) begin : g_bad
      $error("lpcs_scheduler: counter too narrow for delay codes");
   end

   // delay length in clock periods for a code
   function automatic logic [CNT_W-1:0] dlyCycles(input logic [2:0] code,
                                                  input int expBase);
      if (code == 3'h0) begin
         dlyCycles = CNT_W'(SHORT_DLY_CYC);
      end else begin
         dlyCycles = (CNT_W'(1) << (expBase + EXP_STEP * int'(code)))
                     + CNT_W'(DLY_BIAS_CYC);
      end
   endfunction

   // ---------------- bus slave ----------------
   logic        addrPhase;
   logic        dpWrite_r, dpWrite_nxt;
   logic [31:0] dpAddr_r, dpAddr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        wrSoft, wrLp, wrGain, wrCfg;

   assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = rdata_r;
   assign wrSoft    = dpWrite_r && (dpAddr_r == ADDR_SOFT_TRIG);
   assign wrLp      = dpWrite_r && (dpAddr_r == ADDR_LP_CTRL);
   assign wrGain    = dpWrite_r && (dpAddr_r == ADDR_GAIN_TRIM);
   assign wrCfg     = dpWrite_r && (dpAddr_r == ADDR_CAL_CFG);

   // ---------------- registers ----------------
   logic [7:0] softTrig_r, softTrig_nxt;
   logic [7:0] lpCtrl_r, lpCtrl_nxt;
   logic [7:0] gainTrim_r, gainTrim_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic       fuseLoaded_r, fuseLoaded_nxt;
   logic [7:0] status;

   always_comb begin
      softTrig_nxt   = softTrig_r;
      lpCtrl_nxt     = lpCtrl_r;
      gainTrim_nxt   = gainTrim_r;
      cfg_nxt        = cfg_r;
      fuseLoaded_nxt = fuseLoaded_r;
      if (!fuseLoaded_r && fuseTrimValid) begin
         gainTrim_nxt   = fuseTrimValue;
         fuseLoaded_nxt = 1'b1;
      end
      if (wrSoft) begin
         softTrig_nxt = hwdata[7:0];
      end
      if (wrLp) begin
         lpCtrl_nxt = hwdata[7:0];
      end
      if (wrGain) begin
         gainTrim_nxt   = hwdata[7:0];
         fuseLoaded_nxt = 1'b1;
      end
      if (wrCfg) begin
         cfg_nxt = hwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         softTrig_r   <= SOFT_TRIG_RST;
         lpCtrl_r     <= LP_CTRL_RST;
         gainTrim_r   <= GAIN_TRIM_RST;
         cfg_r        <= CAL_CFG_RST;
         fuseLoaded_r <= 1'b0;
      end else begin
         softTrig_r   <= softTrig_nxt;
         lpCtrl_r     <= lpCtrl_nxt;
         gainTrim_r   <= gainTrim_nxt;
         cfg_r        <= cfg_nxt;
         fuseLoaded_r <= fuseLoaded_nxt;
      end
   end

   // read mux sees pending writes so a write then read is never stale
   always_comb begin
      dpWrite_nxt = addrPhase && hwrite;
      dpAddr_nxt  = addrPhase ? haddr : dpAddr_r;
      rdata_nxt   = rdata_r;
      if (addrPhase && !hwrite) begin
         unique case (haddr)
            ADDR_SOFT_TRIG: rdata_nxt = {24'h0, softTrig_nxt};
            ADDR_LP_CTRL:   rdata_nxt = {24'h0, lpCtrl_nxt};
            ADDR_GAIN_TRIM: rdata_nxt = {24'h0, gainTrim_nxt};
            ADDR_CAL_CFG:   rdata_nxt = {24'h0, cfg_nxt};
            ADDR_STATUS:    rdata_nxt = {24'h0, status};
            default:        rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dpWrite_r <= 1'b0;
         dpAddr_r  <= 32'h0;
         rdata_r   <= 32'h0;
      end else begin
         dpWrite_r <= dpWrite_nxt;
         dpAddr_r  <= dpAddr_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // ---------------- trigger path ----------------
   logic [2:0] pinSync_r, pinSync_nxt;
   logic       pinLevel_r, pinLevel_nxt;
   logic       cal_trigger_pin_r, cal_trigger_pin_nxt;

   always_comb begin
      pinSync_nxt  = {pinSync_r[1:0], calTriggerPin};
      pinLevel_nxt = pinLevel_r;
      if (pinSync_r[1] == pinSync_r[2]) begin
         pinLevel_nxt = pinSync_r[2];
      end
      cal_trigger_pin_nxt = cfg_r[TRIG_SEL_BIT] ? pinLevel_r
                                        : softTrig_r[SOFT_TRIG_BIT];
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinSync_r  <= 3'h7; // idle pin is high, no false wake
         pinLevel_r <= 1'b1;
         cal_trigger_pin_r  <= 1'b1;
      end else begin
         pinSync_r  <= pinSync_nxt;
         pinLevel_r <= pinLevel_nxt;
         cal_trigger_pin_r  <= cal_trigger_pin_nxt;
      end
   end

   // ---------------- scheduler ----------------
   lpcs_state_t      state_r, state_nxt;
   logic             calStart_r, calStart_nxt;
   logic             lpActive, lpTrigMode;
   logic             tmrLoad, tmrClear, tmrBusy, tmrDone;
   logic [CNT_W-1:0] tmrValue, sleepCyc, wakeCyc;

   assign lpActive   = lpCtrl_r[LOWPOWER_CAL_ENABLE_BIT] && cfg_r[BG_CAL_BIT];
   assign lpTrigMode = lpCtrl_r[LOWPOWER_TRIGGER_MODE_BIT];
   assign sleepCyc   = dlyCycles(lpCtrl_r[SLEEP_LSB +: 3], SLEEP_EXP);
   assign wakeCyc    = dlyCycles({1'b0, lpCtrl_r[WAKE_LSB +: 2]},
                                 WAKE_EXP);

   always_comb begin
      state_nxt    = state_r;
      calStart_nxt = 1'b0;
      tmrLoad      = 1'b0;
      tmrClear     = 1'b0;
      tmrValue     = sleepCyc;
      if (!lpActive) begin
         state_nxt = ST_IDLE;
         tmrClear  = 1'b1;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
               if (lpTrigMode) begin
                  if (!cal_trigger_pin_r) begin
                     state_nxt = ST_WAKE;
                     tmrLoad   = 1'b1;
                     tmrValue  = wakeCyc;
                  end
               end else if (tmrDone) begin
                  state_nxt = ST_WAKE;
                  tmrLoad   = 1'b1;
                  tmrValue  = wakeCyc;
               end else if (!tmrBusy) begin
                  tmrLoad = 1'b1;
               end
            end
            ST_WAKE: begin
               if (tmrDone) begin
                  state_nxt    = ST_CAL;
                  calStart_nxt = 1'b1;
               end
            end
            ST_CAL: begin
               if (calDone) begin
                  state_nxt = ST_SLEEP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r    <= ST_IDLE;
         calStart_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         calStart_r <= calStart_nxt;
      end
   end

   lpcs_delay_timer #(
      .CNT_W     (CNT_W)
   ) u_timer (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .clear     (tmrClear),
      .load      (tmrLoad),
      .loadValue (tmrValue),
      .busy      (tmrBusy),
      .done      (tmrDone)
   );

   assign calTrigger   = cal_trigger_pin_r;
   assign coreSleep    = (state_r == ST_SLEEP);
   assign coreSettling = (state_r == ST_WAKE);
   assign calStart     = calStart_r;
   assign gainTrim     = gainTrim_r;
   assign status = {3'h0, fuseLoaded_r, state_r == ST_CAL, coreSettling,
                    coreSleep, cal_trigger_pin_r};

   // ---------------- checks ----------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_wakeExpires;
      (state_r == ST_WAKE) && lpActive ##0 tmrDone;
   endsequence

   a_soft_reset_val: assert property ($rose(arst_n) |->
      softTrig_r[SOFT_TRIG_BIT] && cal_trigger_pin_r)
      else $error("software trigger not high after reset");

   a_src_software: assert property (!cfg_r[TRIG_SEL_BIT] ##1
      $stable(softTrig_r) |-> calTrigger == softTrig_r[SOFT_TRIG_BIT])
      else $error("trigger not taken from software bit");

   a_src_pin_sync: assert property (
      (cfg_r[TRIG_SEL_BIT] && $stable(calTriggerPin))[*5] |=>
      calTrigger == $past(calTriggerPin, 1))
      else $error("trigger not following synchronised pin");

   a_sleep_gated: assert property (
      tmrLoad && state_nxt == ST_SLEEP |->
      lpActive && !lpTrigMode && tmrValue == sleepCyc)
      else $error("sleep timer used outside autonomous low power");

   a_cal_after_wake: assert property (calStart_r |->
      $past(state_r) == ST_WAKE && $past(tmrDone))
      else $error("calibration started without settling");

   a_wake_starts: assert property (s_wakeExpires |=>
      calStart_r && state_r == ST_CAL)
      else $error("settling expiry did not start calibration");

   a_trig_wake: assert property (
      state_r == ST_SLEEP && lpActive && lpTrigMode && !cal_trigger_pin_r |=>
      coreSettling || !lpActive)
      else $error("low trigger did not wake the core");

   a_trig_hold: assert property (
      state_r == ST_SLEEP && lpActive && lpTrigMode && cal_trigger_pin_r &&
      $stable(lpCtrl_r) |=> coreSleep || !lpActive)
      else $error("core woke while trigger high");

   a_lp_gating: assert property (!cfg_r[BG_CAL_BIT] |=>
      state_r == ST_IDLE && !calStart_r)
      else $error("low power ran without background calibration");

   a_gain_write: assert property (wrGain |=>
      gainTrim == $past(hwdata[7:0]))
      else $error("gain trim write lost");

   a_fuse_load: assert property (
      !fuseLoaded_r && fuseTrimValid && !wrGain |=>
      gainTrim == $past(fuseTrimValue) && fuseLoaded_r)
      else $error("fuse gain trim not loaded");
endmodule // lpcs_scheduler

//--- testbench/lpcs_trig_source.sv
// external trigger source and calibration engine stand-in
`timescale 1ns/1ps
module lpcs_trig_source (
   input  wire logic       sys_clk,       // sample clock
   input  wire logic       arst_n,        // async reset, active low
   input  wire logic       level,         // commanded pin level
   input  wire logic [7:0] doneDly,       // start to done is doneDly+2 cycles
   input  wire logic       calStart,      // start calibration pulse
   output logic            calTriggerPin, // external trigger pin
   output logic            calDone        // calibration finished pulse
);
   logic [8:0] cnt_r;

   // pin follows the command one cycle late; done doneDly+2 cycles after calStart
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         calTriggerPin <= 1'b1;
         calDone       <= 1'b0;
         cnt_r         <= 9'h0;
      end else begin
         calTriggerPin <= level;
         calDone       <= (cnt_r == 9'h1);
         if (calStart) begin
            cnt_r <= {1'b0, doneDly} + 9'h1;
         end else if (cnt_r != 9'h0) begin
            cnt_r <= cnt_r - 9'h1;
         end
      end
   end
endmodule // lpcs_trig_source

//--- testbench/tb_top.sv
// register-level bench for the low-power calibration scheduler
`timescale 1ns/1ps
module tb_top;
   import lpcs_pkg::*;
   localparam int SLP_E = 1;
   localparam int WAK_E = 2;
   logic        sys_clk;
   logic        arst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        calTriggerPin;
   logic        fuseTrimValid;
   logic [7:0]  fuseTrimValue;
   logic        calDone;
   logic        calTrigger;
   logic        coreSleep;
   logic        coreSettling;
   logic        calStart;
   logic [7:0]  gainTrim;
   logic        pinLevel;
   logic [7:0]  doneDly;
   int          fails;
   int          compares;

   lpcs_scheduler #(.CNT_W(41), .SLEEP_EXP(SLP_E), .WAKE_EXP(WAK_E)) DUT (
      .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .calTriggerPin(calTriggerPin),
      .fuseTrimValid(fuseTrimValid), .fuseTrimValue(fuseTrimValue),
      .calDone(calDone), .calTrigger(calTrigger), .coreSleep(coreSleep),
      .coreSettling(coreSettling), .calStart(calStart), .gainTrim(gainTrim)
   );

   lpcs_trig_source u_src (
      .sys_clk(sys_clk), .arst_n(arst_n), .level(pinLevel),
      .doneDly(doneDly), .calStart(calStart),
      .calTriggerPin(calTriggerPin), .calDone(calDone)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      $display("[ERR] %0t run timed out", $time);
      results();
   end

   task automatic results();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   function automatic int dly(input int e, input int c);
      return (c == 0) ? SHORT_DLY_CYC
                      : (1 << (e + EXP_STEP * c)) + DLY_BIAS_CYC;
   endfunction

   function automatic logic sig(input int s);
      case (s)
         0: return coreSleep;
         1: return coreSettling;
         default: return calStart;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkIn(input int n, input int lo, input int hi);
      compares++;
      if (n < lo || n > hi) begin
         fails++;
         $display("[ERR] %0t count %0d not in %0d..%0d", $time, n, lo, hi);
      end
   endtask

   // count edges until the chosen output shows level v
   task automatic waitLvl(input int s, input logic v, input int lim,
                          output int n);
      n = 0;
      while (sig(s) !== v) begin
         @(posedge sys_clk);
         n++;
         if (n > lim) begin
            fails++;
            $display("[ERR] %0t wait for level timed out", $time);
            results();
         end
      end
   endtask

   task automatic waitRdy();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         fails++;
         $display("[ERR] %0t bus ready timed out", $time);
         results();
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      waitRdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      waitRdy();
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask

   initial begin
      int n;
      fails = 0;
      compares = 0;
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fuseTrimValid = 1'b0;
      fuseTrimValue = 8'h5a;
      pinLevel = 1'b1;
      doneDly = 8'h00;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk(calTrigger, 1'b1);
      rd(ADDR_SOFT_TRIG, SOFT_TRIG_RST);
      rd(ADDR_LP_CTRL, LP_CTRL_RST);
      rd(ADDR_GAIN_TRIM, GAIN_TRIM_RST);
      rd(ADDR_CAL_CFG, CAL_CFG_RST);
      rd(ADDR_STATUS, 32'h01);
      wr(32'h100, 8'hff);
      rd(32'h100, 32'h0);
      // fuse load, then software override
      fuseTrimValid <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(gainTrim, 8'h5a);
      rd(ADDR_GAIN_TRIM, 8'h5a);
      fuseTrimValue <= 8'h11;
      wr(ADDR_GAIN_TRIM, 8'hc3);
      repeat (2) @(posedge sys_clk);
      chk(gainTrim, 8'hc3);
      // trigger source selection
      wr(ADDR_CAL_CFG, 8'h00);
      wr(ADDR_SOFT_TRIG, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk(calTrigger, 1'b0);
      pinLevel <= 1'b0;
      wr(ADDR_SOFT_TRIG, 8'h01);
      repeat (3) @(posedge sys_clk);
      chk(calTrigger, 1'b1);
      wr(ADDR_CAL_CFG, 8'h01);
      repeat (10) @(posedge sys_clk);
      chk(calTrigger, 1'b0);
      pinLevel <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(calTrigger, 1'b0);
      repeat (8) @(posedge sys_clk);
      chk(calTrigger, 1'b1);
      wr(ADDR_SOFT_TRIG, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk(calTrigger, 1'b1);
      // low-power enable without background calibration
      wr(ADDR_CAL_CFG, 8'h00);
      wr(ADDR_LP_CTRL, 8'h89);
      repeat (20) @(posedge sys_clk);
      chk({coreSleep, coreSettling}, 2'b00);
      wr(ADDR_LP_CTRL, 8'h00);
      wr(ADDR_CAL_CFG, 8'h02);
      // autonomous mode over sleep codes 0..4 and every wake code
      for (int k = 0; k < 5; k++) begin
         doneDly <= (k % 2) ? 8'd40 : 8'd0;
         wr(ADDR_LP_CTRL, {k[2:0], k[1:0], 3'b001});
         waitLvl(0, 1'b1, 10, n);
         waitLvl(0, 1'b0, 9000, n);
         chkIn(n, dly(SLP_E, k) - 1, dly(SLP_E, k) + 4);
         waitLvl(1, 1'b0, 2400, n);
         chkIn(n, dly(WAK_E, k % 4) - 1, dly(WAK_E, k % 4) + 4);
         waitLvl(2, 1'b1, 4, n);
         @(posedge sys_clk);
         chk(calStart, 1'b0);
         waitLvl(0, 1'b1, 50, n);
         wr(ADDR_LP_CTRL, 8'h00);
         repeat (2) @(posedge sys_clk);
         chk({coreSleep, coreSettling}, 2'b00);
      end
      // trigger mode: sleep while the pin is high
      wr(ADDR_CAL_CFG, 8'h03);
      wr(ADDR_LP_CTRL, 8'h0b);
      waitLvl(0, 1'b1, 10, n);
      repeat (1300) @(posedge sys_clk);
      chk(coreSleep, 1'b1);
      rd(ADDR_STATUS, 32'h13);
      pinLevel <= 1'b0;
      waitLvl(0, 1'b0, 12, n);
      pinLevel <= 1'b1;
      waitLvl(1, 1'b0, 200, n);
      chkIn(n, dly(WAK_E, 1) - 1, dly(WAK_E, 1) + 4);
      waitLvl(2, 1'b1, 4, n);
      waitLvl(0, 1'b1, 50, n);
      wr(ADDR_LP_CTRL, 8'h00);
      // trigger held high when unused
      wr(ADDR_CAL_CFG, 8'h00);
      wr(ADDR_SOFT_TRIG, 8'h01);
      repeat (3) @(posedge sys_clk);
      chk(calTrigger, 1'b1);
      results();
   end
endmodule // tb_top
